//--- verilog/aro_result_port.sv
`timescale 1ns/100ps
`default_nettype none
module aro_result_port #(
  parameter int CONV_CYCLES = aro_pkg::CONV_CYCLES,
  parameter int SCLK_HALF = aro_pkg::SCLK_HALF
) (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // link clock from the host
  input wire logic serial_bit_clock,
  // host control pins
  input wire logic cs_n,
  input wire logic read_convert,
  input wire logic byte_select,
  input wire logic output_format_select,
  input wire logic clock_source_select,
  // converter core
  input wire logic [15:0] core_result,
  // parallel result lines
  output logic [7:0] parallel_line_o,
  output logic parallel_line_oe,
  // serial result
  output logic serial_result_out,
  output logic serial_bit_clock_o,
  output logic serial_bit_clock_oe,
  // status
  output logic busy
);
  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam int DW = $clog2(SCLK_HALF + 1);

  // pin synchronisers
  logic [aro_pkg::PIN_N-1:0] pin_s1_q;
  logic [aro_pkg::PIN_N-1:0] pin_s2_q;
  logic rc_prev_q;
  logic link_s1_q;
  logic link_s2_q;
  logic link_s3_q;
  logic edge_toggle;

  aro_link_edge u_link_edge (
    .serial_bit_clock(serial_bit_clock),
    .sys_rst(sys_rst),
    .edge_toggle(edge_toggle)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      rc_prev_q <= 1'b0;
      link_s1_q <= 1'b0;
      link_s2_q <= 1'b0;
      link_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= {clock_source_select, output_format_select, byte_select, read_convert, cs_n};
      pin_s2_q <= pin_s1_q;
      rc_prev_q <= pin_s2_q[aro_pkg::PIN_RC];
      link_s1_q <= edge_toggle;
      link_s2_q <= link_s1_q;
      link_s3_q <= link_s2_q;
    end
  end

  logic cs_s;
  logic rc_s;
  logic byte_s;
  logic fmt_s;
  logic clksel_s;
  logic ext_evt;
  logic start;
  assign cs_s = pin_s2_q[aro_pkg::PIN_CS];
  assign rc_s = pin_s2_q[aro_pkg::PIN_RC];
  assign byte_s = pin_s2_q[aro_pkg::PIN_BYTE];
  assign fmt_s = pin_s2_q[aro_pkg::PIN_FMT];
  assign clksel_s = pin_s2_q[aro_pkg::PIN_CLKSEL];
  assign ext_evt = link_s2_q ^ link_s3_q;

  // conversion control
  aro_pkg::aro_conv_e conv_q;
  aro_pkg::aro_conv_e conv_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [15:0] result_q;
  logic [15:0] result_d;
  logic busy_q;
  logic busy_d;
  logic conv_done;

  assign start = rc_prev_q & ~rc_s & ~cs_s & busy_q;

  always_comb begin
    conv_d = conv_q;
    cnt_d = cnt_q;
    result_d = result_q;
    busy_d = busy_q;
    conv_done = 1'b0;
    case (conv_q)
      aro_pkg::CONV_IDLE: begin
        if (start) begin
          conv_d = aro_pkg::CONV_RUN;
          cnt_d = CW'(CONV_CYCLES - 1);
          busy_d = 1'b0;
        end
      end
      aro_pkg::CONV_RUN: begin
        if (cnt_q == '0) begin
          conv_d = aro_pkg::CONV_IDLE;
          result_d = core_result;
          busy_d = 1'b1;
          conv_done = 1'b1;
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      default: begin
        conv_d = aro_pkg::CONV_IDLE;
        busy_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_q <= aro_pkg::CONV_IDLE;
      cnt_q <= '0;
      result_q <= aro_pkg::RESULT_RST;
      busy_q <= 1'b1;
    end else begin
      conv_q <= conv_d;
      cnt_q <= cnt_d;
      result_q <= result_d;
      busy_q <= busy_d;
    end
  end

  // output coding: the core delivers straight binary
  logic [15:0] coded;
  assign coded = (fmt_s == aro_pkg::FMT_STRAIGHT) ? result_q :
                 {~result_q[15], result_q[14:0]};

  // parallel lines; the pin synchroniser and output register add three clk cycles of access time
  logic [7:0] par_d;
  logic par_oe_d;
  always_comb begin
    par_d = (byte_s == aro_pkg::BYTE_LOW_HALF) ? coded[7:0] : coded[15:8];
    par_oe_d = ~cs_s & rc_s;
  end

  // serial shifter, msb first, one bit per falling bit clock edge
  logic [15:0] sh_q;
  logic [15:0] sh_d;
  logic [4:0] bits_q;
  logic [4:0] bits_d;
  logic ser_on_q;
  logic ser_on_d;
  logic int_mode_q;
  logic int_mode_d;
  logic [DW-1:0] div_q;
  logic [DW-1:0] div_d;
  logic sclk_q;
  logic sclk_d;
  logic sclk_oe_d;
  logic shift_evt;

  always_comb begin
    sh_d = sh_q;
    bits_d = bits_q;
    ser_on_d = ser_on_q;
    int_mode_d = int_mode_q;
    div_d = div_q;
    sclk_d = sclk_q;
    shift_evt = 1'b0;
    sclk_oe_d = (clksel_s == aro_pkg::CLKSRC_INT);
    if (ser_on_q) begin
      if (int_mode_q) begin
        if (div_q == DW'(SCLK_HALF - 1)) begin
          div_d = '0;
          sclk_d = ~sclk_q;
          shift_evt = sclk_q;
        end else begin
          div_d = div_q + DW'(1);
        end
      end else begin
        shift_evt = ext_evt;
      end
      if (shift_evt) begin
        if (bits_q == 5'h01) begin
          ser_on_d = 1'b0;
          sh_d = '0;
        end else begin
          sh_d = {sh_q[14:0], 1'b0};
        end
        bits_d = bits_q - 5'h01;
      end
    end
    // a new frame overrides any frame still running
    if (start && clksel_s == aro_pkg::CLKSRC_INT) begin
      sh_d = coded;
      bits_d = aro_pkg::FRAME_BITS;
      ser_on_d = 1'b1;
      int_mode_d = 1'b1;
      div_d = '0;
      sclk_d = 1'b0;
    end else if (conv_done && clksel_s != aro_pkg::CLKSRC_INT) begin
      // external clock: the fresh result waits for the host's clock
      sh_d = (fmt_s == aro_pkg::FMT_STRAIGHT) ? core_result :
             {~core_result[15], core_result[14:0]};
      bits_d = aro_pkg::FRAME_BITS;
      ser_on_d = 1'b1;
      int_mode_d = 1'b0;
      div_d = '0;
      sclk_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sh_q <= '0;
      bits_q <= '0;
      ser_on_q <= 1'b0;
      int_mode_q <= 1'b0;
      div_q <= '0;
      sclk_q <= 1'b0;
      serial_bit_clock_oe <= 1'b0;
      parallel_line_o <= '0;
      parallel_line_oe <= 1'b0;
    end else begin
      sh_q <= sh_d;
      bits_q <= bits_d;
      ser_on_q <= ser_on_d;
      int_mode_q <= int_mode_d;
      div_q <= div_d;
      sclk_q <= sclk_d;
      serial_bit_clock_oe <= sclk_oe_d;
      parallel_line_o <= par_d;
      parallel_line_oe <= par_oe_d;
    end
  end

  assign serial_result_out = sh_q[15];
  assign serial_bit_clock_o = sclk_q;
  assign busy = busy_q;

  // checks
  property p_byte_map;
    @(posedge clk) disable iff (sys_rst)
    1 |=> parallel_line_o == ($past(byte_s) ? $past(coded[7:0]) : $past(coded[15:8]));
  endproperty
  a_byte_map: assert property (p_byte_map) else $error("wrong byte on lines");

  property p_release;
    @(posedge clk) disable iff (sys_rst)
    (cs_s || !rc_s) |=> !parallel_line_oe;
  endproperty
  a_release: assert property (p_release) else $error("lines driven while deselected");

  property p_start;
    @(posedge clk) disable iff (sys_rst)
    (rc_prev_q && !rc_s && !cs_s && busy_q) |=> conv_q == aro_pkg::CONV_RUN && !busy;
  endproperty
  a_start: assert property (p_start) else $error("start edge ignored");

  property p_int_shift;
    @(posedge clk) disable iff (sys_rst)
    (start && !clksel_s) |=> ser_on_q && serial_result_out == $past(coded[15]) ##1 ser_on_q;
  endproperty
  a_int_shift: assert property (p_int_shift) else $error("serial frame not started");

  property p_btc;
    @(posedge clk) disable iff (sys_rst)
    (!byte_s && !fmt_s) |=> parallel_line_o[7] == ~$past(result_q[15]);
  endproperty
  a_btc: assert property (p_btc) else $error("msb not inverted");

  property p_clk_src;
    @(posedge clk) disable iff (sys_rst)
    $stable(clksel_s) |=> serial_bit_clock_oe == !$past(clksel_s);
  endproperty
  a_clk_src: assert property (p_clk_src) else $error("bit clock source wrong");

  property p_busy_rise;
    @(posedge clk) disable iff (sys_rst)
    $rose(busy) |-> $past(conv_q) == aro_pkg::CONV_RUN && $past(cnt_q) == '0;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy rose early");

  property p_busy_fall;
    @(posedge clk) disable iff (sys_rst)
    $fell(busy) |-> $past(start);
  endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("busy fell without start");

  c_conv_done: cover property (@(posedge clk) disable iff (sys_rst) $rose(busy));
  c_int_frame: cover property (@(posedge clk) disable iff (sys_rst) $fell(ser_on_q) && int_mode_q);
  c_ext_frame: cover property (@(posedge clk) disable iff (sys_rst) $fell(ser_on_q) && !int_mode_q);
endmodule : aro_result_port
`default_nettype wire

//--- verilog/aro_pkg.sv
package aro_pkg;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  // timing: conversion time in ns, clock period in ns, least time rounds up
  localparam int CLK_PERIOD_NS = 8;
  localparam int CONV_TIME_NS = 20000;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // internal bit clock: half period in clk cycles
  localparam int SCLK_HALF = 4;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  // pin levels
  localparam logic FMT_STRAIGHT = 1'b1;
  localparam logic CLKSRC_INT = 1'b0;
  localparam logic BYTE_LOW_HALF = 1'b1;
  // synchroniser bit positions
  localparam int PIN_CS = 0;
  localparam int PIN_RC = 1;
  localparam int PIN_BYTE = 2;
  localparam int PIN_FMT = 3;
  localparam int PIN_CLKSEL = 4;
  localparam int PIN_N = 5;
  typedef enum logic {
    CONV_IDLE = 1'b0,
    CONV_RUN = 1'b1
  } aro_conv_e;
endpackage : aro_pkg

//--- verilog/aro_link_edge.sv
`timescale 1ns/100ps
`default_nettype none
// counts falling edges of the external bit clock as a toggle, so the
// event crosses to the system clock without losing edges
module aro_link_edge (
  // link clock and reset
  input wire logic serial_bit_clock,
  input wire logic sys_rst,
  // event toggle
  output logic edge_toggle
);
  logic toggle_q;
  logic toggle_d;

  always_comb begin
    toggle_d = ~toggle_q;
  end

  // the link clock stands still outside frames, so a reset that waited for
  // link edges would leave the toggle unknown; the system reset clears it.
  // limitation: no link edge may fall right at reset release
  always_ff @(negedge serial_bit_clock or posedge sys_rst) begin
    if (sys_rst) begin
      toggle_q <= 1'b0;
    end else begin
      toggle_q <= toggle_d;
    end
  end

  assign edge_toggle = toggle_q;
endmodule : aro_link_edge
`default_nettype wire

//--- testbench/aro_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module aro_host_model (
  // parallel bus
  input wire logic [7:0] lines_o,
  input wire logic lines_oe,
  output logic [7:0] bus,
  // serial link
  input wire logic frame_go,
  input wire logic sdo,
  output logic sclk,
  output logic [15:0] word
);
  logic [7:0] last = 8'h00;
  // a released bus must not look like a stale copy of the last byte
  assign bus = lines_oe ? lines_o : ~last;
  always @(lines_o or lines_oe) if (lines_oe) last = lines_o;
  initial sclk = 1'b0;
  // link clock stands low outside frames; bits taken on the rise
  always @(posedge frame_go) begin
    #37;
    for (int i = 0; i < 16; i++) begin
      #80 sclk = 1'b1;
      word = {word[14:0], sdo};
      #80 sclk = 1'b0;
    end
  end
endmodule : aro_host_model
`default_nettype wire

//--- testbench/adc_result_output_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
module adc_result_output_port_tb;
  localparam int CONV = 20;
  logic clk, sys_rst, cs_n, read_convert, byte_select, fmt, clk_sel, frame_go;
  logic [15:0] core_result, word, int_word;
  logic [7:0] lines_o, bus;
  logic lines_oe, sdo, sclk, sclk_o, sclk_oe, busy;
  int fails = 0;
  int checked = 0;
  logic [4:0] rows [7] = '{5'h0b, 5'h0f, 5'h09, 5'h0d, 5'h1a, 5'h12, 5'h02};
  aro_result_port #(.CONV_CYCLES(CONV), .SCLK_HALF(1)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .serial_bit_clock(sclk), .cs_n(cs_n), .read_convert(read_convert),
    .byte_select(byte_select), .output_format_select(fmt), .clock_source_select(clk_sel),
    .core_result(core_result), .parallel_line_o(lines_o), .parallel_line_oe(lines_oe),
    .serial_result_out(sdo), .serial_bit_clock_o(sclk_o), .serial_bit_clock_oe(sclk_oe),
    .busy(busy));
  aro_host_model host_u (.lines_o(lines_o), .lines_oe(lines_oe), .bus(bus),
    .frame_go(frame_go), .sdo(sdo), .sclk(sclk), .word(word));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge sclk_o) int_word <= {int_word[14:0], sdo};
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  function automatic logic [7:0] exp_byte(input logic [15:0] r, input logic b, input logic f);
    logic [15:0] c;
    c = f ? r : {~r[15], r[14:0]};
    return b ? c[7:0] : c[15:8];
  endfunction : exp_byte
  task automatic convert(input logic sel);
    int n;
    n = 0;
    @(posedge clk);
    clk_sel <= sel;
    cs_n <= 1'b0;
    tick(4);
    read_convert <= 1'b0;
    while (busy !== 1'b0 && n < 10) begin
      @(negedge clk);
      n++;
    end
    check("start", 16'(busy), 16'h0000);
    check("clk_oe", 16'(sclk_oe), 16'(!sel));
    n = 0;
    while (busy === 1'b0 && n < CONV + 9) begin
      @(negedge clk);
      n++;
    end
    check("busy_low", 16'(n == CONV || n == CONV + 1), 16'h0001);
    @(posedge clk);
    read_convert <= 1'b1;
  endtask : convert
  initial begin
    #100000;
    fails++;
    close_out();
  end
  initial begin
    sys_rst = 1'b1;
    cs_n = 1'b1;
    read_convert = 1'b1;
    byte_select = 1'b0;
    fmt = 1'b1;
    clk_sel = 1'b0;
    frame_go = 1'b0;
    core_result = 16'h9a3c;
    tick(2);
    sys_rst <= 1'b0;
    @(negedge clk);
    check("rst_oe", 16'(lines_oe), 16'h0000);
    check("rst_busy", 16'(busy), 16'h0001);
    // falling edge while deselected must be ignored
    tick(4);
    read_convert <= 1'b0;
    repeat (8) begin
      @(negedge clk);
      check("refused", 16'(busy), 16'h0001);
    end
    @(posedge clk);
    read_convert <= 1'b1;
    convert(1'b0);
    core_result <= 16'h4e71;
    convert(1'b0);
    tick(40);
    check("serial_int", int_word, 16'h9a3c);
    foreach (rows[i]) begin
      @(posedge clk);
      {cs_n, read_convert, byte_select, fmt} <= rows[i][4:1];
      repeat (4) @(negedge clk);
      check("oe", 16'(lines_oe), 16'(rows[i][0]));
      if (rows[i][0]) begin
        check("lines", 16'(bus), 16'(exp_byte(16'h4e71, rows[i][2], rows[i][1])));
      end
    end
    @(posedge clk);
    fmt <= 1'b1;
    read_convert <= 1'b1;
    core_result <= 16'hc35a;
    convert(1'b1);
    frame_go <= 1'b1;
    #2800;
    check("serial_ext", word, 16'hc35a);
    // reset after the external frame: outputs back to idle, stored result cleared
    @(posedge clk);
    sys_rst <= 1'b1;
    tick(2);
    sys_rst <= 1'b0;
    @(negedge clk);
    check("rst2_oe", 16'(lines_oe), 16'h0000);
    check("rst2_busy", 16'(busy), 16'h0001);
    check("rst2_sdo", 16'(sdo), 16'h0000);
    repeat (3) @(negedge clk);
    check("rst2_oe_on", 16'(lines_oe), 16'h0001);
    check("rst2_lines", 16'(bus), 16'(exp_byte(aro_pkg::RESULT_RST, byte_select, fmt)));
    close_out();
  end
endmodule : adc_result_output_port_tb
`default_nettype wire
